// ### logic/supply_monitor_pkg.sv
/*
 Constants, register map and field layout for the supply monitor event router.
 Assumes one 25 MHz system clock and a synchronous active-low reset from the device core.
*/
package supply_monitor_pkg;

	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned SRC_A_N = 8;
	localparam int unsigned SRC_B_N = 7;
	localparam int unsigned SRC_N = 15;
	localparam int unsigned DAC_N = 2;
	localparam int unsigned CODE_W = 6;
	localparam int unsigned CURR_W = 10;

	typedef logic [ADDR_W-1:0] reg_addr_t;
	typedef logic [DATA_W-1:0] reg_data_t;
	typedef logic [SRC_N-1:0] src_vec_t;
	typedef logic [SRC_N-1:0][DATA_W-1:0] src_meas_t;
	typedef logic [CODE_W-1:0] dac_code_t;
	typedef logic [CURR_W-1:0] dac_curr_t;

	// Register offsets
	localparam reg_addr_t ENABLE_A_ADDR = 7'h21;
	localparam reg_addr_t ENABLE_B_ADDR = 7'h22;
	localparam reg_addr_t ROUTE_A_ADDR = 7'h23;
	localparam reg_addr_t ROUTE_B_ADDR = 7'h24;
	localparam reg_addr_t FLAGS_A_ADDR = 7'h25;
	localparam reg_addr_t FLAGS_B_ADDR = 7'h26;
	localparam reg_addr_t THERM_ONE_ADDR = 7'h27;
	localparam reg_addr_t THERM_TWO_ADDR = 7'h28;

	// Field layout and reset values
	localparam reg_data_t REG_RESET = 8'h00;
	localparam reg_data_t GROUP_B_MASK = 8'h7F;
	localparam reg_data_t CURR_REG_MASK = 8'h7F;
	localparam int unsigned CURR_EN_BIT = 6;
	localparam int unsigned RAIL_THREE_BIT = 6;
	localparam int unsigned RAIL_FOUR_BIT = 7;

	// Current source scale: full scale minus one step per code
	localparam dac_curr_t CURR_FULL_MA = 10'h237;
	localparam dac_curr_t CURR_STEP_MA = 10'h009;

	// Serial frame: write flag, 7 address bits, 8 data bits, most significant first
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] HDR_BITS = 5'h08;
	localparam logic [4:0] LAST_BIT = 5'h0F;
	localparam logic FRAME_WRITE = 1'b1;

endpackage : supply_monitor_pkg

// ### logic/serial_control_slave.sv
/*
 Serial control port slave: 16-bit frames, sampled on the system clock.
 Assumes the serial clock is much slower than the system clock and that inputs are synchronous.
*/
`timescale 1ns/1ps
module serial_control_slave
	import supply_monitor_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Serial pins
	input wire logic sclk_i,
	input wire logic sen_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_n_o,
	// Register side
	output supply_monitor_pkg::reg_addr_t rd_addr_o,
	input wire supply_monitor_pkg::reg_data_t rd_data_i,
	output logic wr_stb_o,
	output supply_monitor_pkg::reg_addr_t wr_addr_o,
	output supply_monitor_pkg::reg_data_t wr_data_o
);
	import supply_monitor_pkg::*;

	logic sclk_reg;
	logic [4:0] cnt_reg;
	logic [14:0] rx_reg;
	reg_data_t tx_reg;
	logic is_read_reg;

	wire sclk_rise = sclk_i && !sclk_reg;
	wire sclk_fall = !sclk_i && sclk_reg;
	wire last_rise = sclk_rise && !sen_n_i && (cnt_reg == LAST_BIT);

	assign rd_addr_o = rx_reg[ADDR_W-1:0];
	assign sdo_o = tx_reg[DATA_W-1];
	assign sdo_oe_n_o = !(is_read_reg && !sen_n_i && (cnt_reg >= HDR_BITS));

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			sclk_reg <= 1'b0;
			cnt_reg <= '0;
			rx_reg <= '0;
			tx_reg <= REG_RESET;
			is_read_reg <= 1'b0;
		end
		else
		begin
			sclk_reg <= sclk_i;
			if (sen_n_i)
			begin
				cnt_reg <= '0;
				is_read_reg <= 1'b0;
			end
			else if (sclk_rise && cnt_reg < FRAME_BITS)
			begin
				rx_reg <= {rx_reg[13:0], sdi_i};
				cnt_reg <= cnt_reg + 5'h01;
			end
			else if (sclk_fall && cnt_reg == HDR_BITS)
			begin
				// Address is complete: load read data ahead of the first data edge
				is_read_reg <= (rx_reg[ADDR_W] != FRAME_WRITE);
				tx_reg <= rd_data_i;
			end
			else if (sclk_fall && cnt_reg > HDR_BITS)
				tx_reg <= {tx_reg[DATA_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			wr_stb_o <= 1'b0;
			wr_addr_o <= '0;
			wr_data_o <= REG_RESET;
		end
		else
		begin
			wr_stb_o <= last_rise && (rx_reg[14] == FRAME_WRITE);
			if (last_rise)
			begin
				wr_addr_o <= rx_reg[13:7];
				wr_data_o <= {rx_reg[6:0], sdi_i};
			end
		end
	end

endmodule : serial_control_slave

// ### logic/thermistor_current_dac.sv
/*
 Digital side of one thermistor current source: magnitude and pin release.
 Assumes the analog source follows current_ma_o and floats the pin when pin_oe_n_o is high.
*/
`timescale 1ns/1ps
module thermistor_current_dac
	import supply_monitor_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Control
	input wire logic enable_i,
	input wire supply_monitor_pkg::dac_code_t code_i,
	// Analog side
	output supply_monitor_pkg::dac_curr_t current_ma_o,
	output logic pin_oe_n_o
);
	import supply_monitor_pkg::*;

	// Linear scale: each code step removes one equal step, code 63 gives zero
	wire dac_curr_t scaled = CURR_FULL_MA - (CURR_STEP_MA * {4'h0, code_i});
	wire dac_curr_t current_next = enable_i ? scaled : '0;

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			current_ma_o <= '0;
			pin_oe_n_o <= 1'b1;
		end
		else
		begin
			current_ma_o <= current_next;
			pin_oe_n_o <= !enable_i;
		end
	end

endmodule : thermistor_current_dac

// ### logic/supply_monitor_event_router.sv
/*
 Supply monitor event router: limit comparison, sticky flags, enable and route registers,
 interrupt and global reset requests, and the two thermistor current source controls.
 Assumes measurements and limits arrive from the converter core, synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module supply_monitor_event_router
	import supply_monitor_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Serial control port
	input wire logic sclk_i,
	input wire logic sen_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_n_o,
	// Monitor inputs, sources 0..7 first group, 8..14 second group
	input wire supply_monitor_pkg::src_meas_t meas_value_i,
	input wire supply_monitor_pkg::src_meas_t under_limit_i,
	input wire supply_monitor_pkg::src_meas_t over_limit_i,
	// Event outputs
	output logic interrupt_out_n_o,
	output logic global_reset_req_o,
	// Thermistor current sources
	output supply_monitor_pkg::dac_curr_t thermistor_one_current_ma_o,
	output supply_monitor_pkg::dac_curr_t thermistor_two_current_ma_o,
	output logic thermistor_one_pin_oe_n_o,
	output logic thermistor_two_pin_oe_n_o
);
	import supply_monitor_pkg::*;

	reg_addr_t rd_addr;
	reg_data_t rd_data;
	logic wr_stb;
	reg_addr_t wr_addr;
	reg_data_t wr_data;

	reg_data_t event_enable_a_reg;
	reg_data_t event_enable_b_reg;
	reg_data_t event_route_a_reg;
	reg_data_t event_route_b_reg;
	reg_data_t thermistor_one_current_reg;
	reg_data_t thermistor_two_current_reg;
	src_vec_t event_flags_reg;
	src_vec_t event_flags_next;
	logic interrupt_out_n_next;
	logic global_reset_req_next;

	src_vec_t out_of_limit;
	src_vec_t enable_vec;
	src_vec_t route_vec;
	src_vec_t irq_pending;
	src_vec_t reset_pending;

	serial_control_slave u_port (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.sclk_i(sclk_i),
		.sen_n_i(sen_n_i),
		.sdi_i(sdi_i),
		.sdo_o(sdo_o),
		.sdo_oe_n_o(sdo_oe_n_o),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.wr_stb_o(wr_stb),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data)
	);

	// Limit comparison, one comparator pair per source
	genvar g;
	generate
		for (g = 0; g < SRC_N; g++)
		begin : g_cmp
			assign out_of_limit[g] = (meas_value_i[g] < under_limit_i[g])
				|| (meas_value_i[g] > over_limit_i[g]);
		end
	endgenerate

	// Both groups joined into one vector in their register bit order
	assign enable_vec = {event_enable_b_reg[SRC_B_N-1:0], event_enable_a_reg};
	assign route_vec = {event_route_b_reg[SRC_B_N-1:0], event_route_a_reg};

	// A cleared enable bit removes the source from both paths
	assign irq_pending = event_flags_reg & enable_vec & ~route_vec;
	assign reset_pending = out_of_limit & enable_vec & route_vec;

	assign event_flags_next = event_flags_reg | out_of_limit;
	assign interrupt_out_n_next = !(|irq_pending);
	assign global_reset_req_next = |reset_pending;

	// Register write decode
	wire wr_enable_a = wr_stb && (wr_addr == ENABLE_A_ADDR);
	wire wr_enable_b = wr_stb && (wr_addr == ENABLE_B_ADDR);
	wire wr_route_a = wr_stb && (wr_addr == ROUTE_A_ADDR);
	wire wr_route_b = wr_stb && (wr_addr == ROUTE_B_ADDR);
	wire wr_therm_one = wr_stb && (wr_addr == THERM_ONE_ADDR);
	wire wr_therm_two = wr_stb && (wr_addr == THERM_TWO_ADDR);

	// Read decode; flag registers are read-only and unmapped offsets read zero
	wire reg_data_t flags_a_rd = event_flags_reg[SRC_A_N-1:0];
	wire reg_data_t flags_b_rd = {1'b0, event_flags_reg[SRC_N-1:SRC_A_N]};
	assign rd_data =
		(rd_addr == ENABLE_A_ADDR) ? event_enable_a_reg :
		(rd_addr == ENABLE_B_ADDR) ? event_enable_b_reg :
		(rd_addr == ROUTE_A_ADDR) ? event_route_a_reg :
		(rd_addr == ROUTE_B_ADDR) ? event_route_b_reg :
		(rd_addr == FLAGS_A_ADDR) ? flags_a_rd :
		(rd_addr == FLAGS_B_ADDR) ? flags_b_rd :
		(rd_addr == THERM_ONE_ADDR) ? thermistor_one_current_reg :
		(rd_addr == THERM_TWO_ADDR) ? thermistor_two_current_reg :
		REG_RESET;

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			event_enable_a_reg <= REG_RESET;
			event_enable_b_reg <= REG_RESET;
			event_route_a_reg <= REG_RESET;
			event_route_b_reg <= REG_RESET;
		end
		else
		begin
			if (wr_enable_a)
				event_enable_a_reg <= wr_data;
			if (wr_enable_b)
				event_enable_b_reg <= wr_data & GROUP_B_MASK;
			if (wr_route_a)
				event_route_a_reg <= wr_data;
			if (wr_route_b)
				event_route_b_reg <= wr_data & GROUP_B_MASK;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			thermistor_one_current_reg <= REG_RESET;
			thermistor_two_current_reg <= REG_RESET;
		end
		else
		begin
			if (wr_therm_one)
				thermistor_one_current_reg <= wr_data & CURR_REG_MASK;
			if (wr_therm_two)
				thermistor_two_current_reg <= wr_data & CURR_REG_MASK;
		end
	end

	// Flags clear only on reset; events are recorded whatever the enable bits say
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			event_flags_reg <= '0;
			interrupt_out_n_o <= 1'b1;
			global_reset_req_o <= 1'b0;
		end
		else
		begin
			event_flags_reg <= event_flags_next;
			interrupt_out_n_o <= interrupt_out_n_next;
			global_reset_req_o <= global_reset_req_next;
		end
	end

	// Current sources
	thermistor_current_dac u_dac_one (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.enable_i(thermistor_one_current_reg[CURR_EN_BIT]),
		.code_i(thermistor_one_current_reg[CODE_W-1:0]),
		.current_ma_o(thermistor_one_current_ma_o),
		.pin_oe_n_o(thermistor_one_pin_oe_n_o)
	);

	thermistor_current_dac u_dac_two (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.enable_i(thermistor_two_current_reg[CURR_EN_BIT]),
		.code_i(thermistor_two_current_reg[CODE_W-1:0]),
		.current_ma_o(thermistor_two_current_ma_o),
		.pin_oe_n_o(thermistor_two_pin_oe_n_o)
	);

	// Checks

	chk_flag_sticky_hold: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		1'b1 |=> ((event_flags_reg & $past(event_flags_reg)) == $past(event_flags_reg)))
	else $error("a set event flag was lost without reset");

	chk_flag_event_set: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(|out_of_limit) |=> ((event_flags_reg & $past(out_of_limit)) == $past(out_of_limit)))
	else $error("an out-of-limit event did not set its flag");

	chk_flag_no_spurious: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(out_of_limit == '0) |=> (event_flags_reg == $past(event_flags_reg)))
	else $error("a flag changed without an event");

	chk_flag_reset_clear: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> (event_flags_reg == '0))
	else $error("flags not clear after reset");

	chk_irq_assert_path: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(|(event_flags_reg & enable_vec & ~route_vec)) |=> !interrupt_out_n_o)
	else $error("interrupt not asserted for an enabled flag");

	chk_irq_mask_block: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		((event_flags_reg & enable_vec & ~route_vec) == '0) |=> interrupt_out_n_o)
	else $error("interrupt asserted with no enabled flag");

	chk_reset_route_raise: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(|(out_of_limit & enable_vec & route_vec)) |=> global_reset_req_o)
	else $error("global reset not requested for routed event");

	chk_reset_mask_block: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		((out_of_limit & enable_vec & route_vec) == '0) |=> !global_reset_req_o)
	else $error("global reset requested without enabled routed event");

	chk_rail_four_enable: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(out_of_limit[RAIL_FOUR_BIT] && event_enable_a_reg[RAIL_FOUR_BIT] && event_route_a_reg[RAIL_FOUR_BIT])
		|=> global_reset_req_o)
	else $error("rail four event ignored while enabled");

	chk_group_b_bit7: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_enable_b |=> (event_enable_b_reg == ($past(wr_data) & GROUP_B_MASK)))
	else $error("second enable register write wrong");

	chk_route_a_store: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_route_a |=> (event_route_a_reg == $past(wr_data)))
	else $error("first route register did not store write");

	chk_dac_off_float: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!thermistor_one_current_reg[CURR_EN_BIT] [*2]
		|-> (thermistor_one_pin_oe_n_o && (thermistor_one_current_ma_o == '0)))
	else $error("disabled current source still driving");

	chk_dac_code_scale: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		thermistor_two_current_reg[CURR_EN_BIT]
		|=> (thermistor_two_current_ma_o
			== CURR_FULL_MA - (CURR_STEP_MA * {4'h0, $past(thermistor_two_current_reg[CODE_W-1:0])})))
	else $error("current magnitude does not match code");

	chk_dac_on_drive: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		thermistor_two_current_reg[CURR_EN_BIT] |=> !thermistor_two_pin_oe_n_o)
	else $error("enabled current source pin not driven");

	chk_rail_three_enable: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(out_of_limit[RAIL_THREE_BIT] && event_enable_a_reg[RAIL_THREE_BIT] && event_route_a_reg[RAIL_THREE_BIT])
		|=> global_reset_req_o)
	else $error("rail three event ignored while enabled");

	chk_enable_a_store: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_enable_a
		|=> (event_enable_a_reg == $past(wr_data)))
	else $error("first enable register did not store write");

	chk_route_b_store: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_route_b
		|=> (event_route_b_reg == ($past(wr_data) & GROUP_B_MASK)))
	else $error("second route register write wrong");

	chk_therm_one_store: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_therm_one
		|=> (thermistor_one_current_reg == ($past(wr_data) & CURR_REG_MASK)))
	else $error("first current register write wrong");

	chk_therm_two_store: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_therm_two
		|=> (thermistor_two_current_reg == ($past(wr_data) & CURR_REG_MASK)))
	else $error("second current register write wrong");

	chk_dac_two_float: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!thermistor_two_current_reg[CURR_EN_BIT] [*2]
		|-> (thermistor_two_pin_oe_n_o && (thermistor_two_current_ma_o == '0)))
	else $error("disabled second current source still driving");

	chk_dac_one_drive: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		thermistor_one_current_reg[CURR_EN_BIT]
		|=> !thermistor_one_pin_oe_n_o)
	else $error("enabled first current source pin not driven");

	chk_dac_full_scale: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(thermistor_one_current_reg[CURR_EN_BIT] && (thermistor_one_current_reg[CODE_W-1:0] == '0))
		|=> (thermistor_one_current_ma_o == CURR_FULL_MA))
	else $error("lowest code does not give full current");

	chk_dac_zero_scale: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(thermistor_one_current_reg[CURR_EN_BIT] && (thermistor_one_current_reg[CODE_W-1:0] == '1))
		|=> (thermistor_one_current_ma_o == '0))
	else $error("highest code does not give zero current");

	chk_flags_a_read_only: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(wr_stb && (wr_addr == FLAGS_A_ADDR) && (out_of_limit == '0))
		|=> (event_flags_reg == $past(event_flags_reg)))
	else $error("write changed the first flag register");

	chk_flags_b_read_only: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(wr_stb && (wr_addr == FLAGS_B_ADDR) && (out_of_limit == '0))
		|=> (event_flags_reg == $past(event_flags_reg)))
	else $error("write changed the second flag register");

	chk_mask_all_quiet: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(enable_vec == '0)
		|=> (interrupt_out_n_o && !global_reset_req_o))
	else $error("event acted with every source disabled");

	chk_irq_low_source: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!interrupt_out_n_o
		|-> $past(|(event_flags_reg & enable_vec & ~route_vec)))
	else $error("interrupt low without an enabled flag");

	chk_reset_req_source: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		global_reset_req_o
		|-> $past(|(out_of_limit & enable_vec & route_vec)))
	else $error("global reset request without a routed event");

endmodule : supply_monitor_event_router

// ### tb/serial_host_model.sv
/*
 Host side of the serial control port: drives frames and collects read data.
 Assumes the design samples sclk on clk_sys_i and needs each sclk phase to last two clocks or more.
*/
`timescale 1ns/1ps
module serial_host_model
	import supply_monitor_pkg::*;
(
	// Clock
	input wire logic clk_sys_i,
	// Serial pins
	output logic sclk_o,
	output logic sen_n_o,
	output logic sdi_o,
	input wire logic sdo_i,
	input wire logic sdo_oe_n_i
);
	import supply_monitor_pkg::*;

	initial
	begin
		sclk_o = 1'b0;
		sen_n_o = 1'b1;
		sdi_o = 1'b0;
	end

	task automatic xfer(input logic wr, input supply_monitor_pkg::reg_addr_t addr,
		input supply_monitor_pkg::reg_data_t wdata, output supply_monitor_pkg::reg_data_t rdata);
		logic [15:0] frame;
		frame = {wr, addr, wdata};
		rdata = 8'h00;
		@(posedge clk_sys_i);
		sen_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			@(posedge clk_sys_i);
			sclk_o <= 1'b0;
			sdi_o <= frame[i];
			repeat (3) @(posedge clk_sys_i);
			// A released output reads as the inverse of its last level
			if (i < 8)
				rdata[i] = sdo_oe_n_i ? ~sdo_i : sdo_i;
			sclk_o <= 1'b1;
			repeat (2) @(posedge clk_sys_i);
		end
		@(posedge clk_sys_i);
		sclk_o <= 1'b0;
		@(posedge clk_sys_i);
		sen_n_o <= 1'b1;
		sdi_o <= ~sdi_o;
		repeat (2) @(posedge clk_sys_i);
	endtask : xfer
endmodule : serial_host_model

// ### tb/supply_monitor_event_router_tb.sv
/*
 Self-checking bench for the supply monitor event router.
 Assumes registers are reached only through the serial host model.
*/
`timescale 1ns/1ps
module supply_monitor_event_router_tb;
	import supply_monitor_pkg::*;
	logic clk_sys_i, rst_n_i, sclk, sen_n, sdi, sdo, sdo_oe_n, irq_n, greq, oe1_n, oe2_n;
	src_meas_t meas, under, over;
	dac_curr_t cur1, cur2;
	reg_data_t d;
	int n_errors = 0;
	int n_checks = 0;

	supply_monitor_event_router u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
		.sen_n_i(sen_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .meas_value_i(meas),
		.under_limit_i(under), .over_limit_i(over), .interrupt_out_n_o(irq_n), .global_reset_req_o(greq),
		.thermistor_one_current_ma_o(cur1), .thermistor_two_current_ma_o(cur2),
		.thermistor_one_pin_oe_n_o(oe1_n), .thermistor_two_pin_oe_n_o(oe2_n));
	serial_host_model u_host (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .sen_n_o(sen_n), .sdi_o(sdi),
		.sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	task automatic summarize;
		$display("Checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : tick

	task automatic wr_reg(input reg_addr_t a, input reg_data_t v);
		reg_data_t dummy;
		u_host.xfer(1'b1, a, v, dummy);
	endtask : wr_reg

	task automatic rd_reg(input reg_addr_t a, output reg_data_t v);
		u_host.xfer(1'b0, a, 8'h00, v);
	endtask : rd_reg

	task automatic do_reset;
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		tick(1);
	endtask : do_reset

	task automatic t_reset_values;
		for (int a = 'h21; a <= 'h28; a++)
		begin
			rd_reg(reg_addr_t'(a), d);
			check("reset register", {8'h00, d}, 16'h0000);
		end
		check("interrupt idle", {15'h0000, irq_n}, 16'h0001);
		check("reset request idle", {15'h0000, greq}, 16'h0000);
		check("pin one released", {15'h0000, oe1_n}, 16'h0001);
		check("current one off", {6'h00, cur1}, 16'h0000);
		check("pin two released", {15'h0000, oe2_n}, 16'h0001);
		check("current two off", {6'h00, cur2}, 16'h0000);
	endtask : t_reset_values

	task automatic t_reg_access;
		reg_addr_t addr [6];
		reg_data_t mask [6];
		reg_data_t pat [3];
		addr = '{ENABLE_A_ADDR, ENABLE_B_ADDR, ROUTE_A_ADDR, ROUTE_B_ADDR, THERM_ONE_ADDR, THERM_TWO_ADDR};
		mask = '{8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'h7F, 8'h7F};
		pat = '{8'hFF, 8'hA5, 8'h5A};
		foreach (pat[p])
			foreach (addr[i])
			begin
				wr_reg(addr[i], pat[p]);
				rd_reg(addr[i], d);
				check("register readback", {8'h00, d}, {8'h00, pat[p] & mask[i]});
			end
		wr_reg(FLAGS_A_ADDR, 8'hFF);
		rd_reg(FLAGS_A_ADDR, d);
		check("flags a read only", {8'h00, d}, 16'h0000);
		wr_reg(FLAGS_B_ADDR, 8'hFF);
		rd_reg(FLAGS_B_ADDR, d);
		check("flags b read only", {8'h00, d}, 16'h0000);
		wr_reg(7'h30, 8'hFF);
		rd_reg(7'h30, d);
		check("unmapped read", {8'h00, d}, 16'h0000);
		foreach (addr[i])
			wr_reg(addr[i], 8'h00);
	endtask : t_reg_access

	task automatic t_masked_event;
		wr_reg(ROUTE_A_ADDR, 8'h40);
		@(posedge clk_sys_i);
		meas[6] <= 8'h05;
		tick(3);
		check("masked reset request", {15'h0000, greq}, 16'h0000);
		check("masked interrupt", {15'h0000, irq_n}, 16'h0001);
		@(posedge clk_sys_i);
		meas[6] <= 8'h80;
		rd_reg(FLAGS_A_ADDR, d);
		check("sticky flag rail three", {8'h00, d}, 16'h0040);
	endtask : t_masked_event

	task automatic t_routing;
		wr_reg(ROUTE_A_ADDR, 8'h00);
		wr_reg(ENABLE_A_ADDR, 8'h40);
		tick(2);
		check("interrupt from flag", {15'h0000, irq_n}, 16'h0000);
		wr_reg(ROUTE_A_ADDR, 8'h40);
		tick(2);
		check("interrupt rerouted", {15'h0000, irq_n}, 16'h0001);
		@(posedge clk_sys_i);
		meas[6] <= 8'h02;
		tick(2);
		check("reset request live", {15'h0000, greq}, 16'h0001);
		@(posedge clk_sys_i);
		meas[6] <= 8'h80;
		tick(2);
		check("reset request ends", {15'h0000, greq}, 16'h0000);
		wr_reg(ENABLE_A_ADDR, 8'h80);
		@(posedge clk_sys_i);
		meas[7] <= 8'hF5;
		tick(3);
		check("rail four interrupt", {15'h0000, irq_n}, 16'h0000);
		wr_reg(ROUTE_A_ADDR, 8'h80);
		tick(1);
		check("rail four reset request", {15'h0000, greq}, 16'h0001);
		check("rail four no interrupt", {15'h0000, irq_n}, 16'h0001);
		@(posedge clk_sys_i);
		meas[7] <= 8'h80;
		wr_reg(ENABLE_B_ADDR, 8'h04);
		wr_reg(ROUTE_B_ADDR, 8'h04);
		@(posedge clk_sys_i);
		meas[10] <= 8'hF5;
		tick(2);
		check("temperature reset request", {15'h0000, greq}, 16'h0001);
		@(posedge clk_sys_i);
		meas[10] <= 8'h80;
		rd_reg(FLAGS_B_ADDR, d);
		check("flags b order", {8'h00, d}, 16'h0004);
	endtask : t_routing

	task automatic t_dac;
		logic [5:0] codes [5];
		codes = '{6'h00, 6'h01, 6'h1F, 6'h3E, 6'h3F};
		foreach (codes[i])
		begin
			wr_reg(THERM_ONE_ADDR, {2'b01, codes[i]});
			wr_reg(THERM_TWO_ADDR, {2'b01, ~codes[i]});
			tick(2);
			check("current one", {6'h00, cur1}, 16'h0237 - 16'h0009 * codes[i]);
			check("current two", {6'h00, cur2}, 16'h0237 - 16'h0009 * (6'h3F - codes[i]));
			check("pin two driven", {15'h0000, oe2_n}, 16'h0000);
			check("pin one driven", {15'h0000, oe1_n}, 16'h0000);
		end
		wr_reg(THERM_ONE_ADDR, 8'h05);
		tick(2);
		check("disabled current", {6'h00, cur1}, 16'h0000);
		check("disabled pin", {15'h0000, oe1_n}, 16'h0001);
	endtask : t_dac

	task automatic t_reset_clears;
		do_reset();
		rd_reg(FLAGS_A_ADDR, d);
		check("flags cleared", {8'h00, d}, 16'h0000);
		check("interrupt cleared", {15'h0000, irq_n}, 16'h0001);
	endtask : t_reset_clears

	initial
	begin
		rst_n_i = 1'b0;
		for (int i = 0; i < SRC_N; i++)
		begin
			meas[i] = 8'h80;
			under[i] = 8'h10;
			over[i] = 8'hF0;
		end
		do_reset();
		t_reset_values();
		t_reg_access();
		t_masked_event();
		t_routing();
		t_dac();
		t_reset_clears();
		summarize();
	end

	initial
	begin
		repeat (40000) @(posedge clk_sys_i);
		n_errors++;
		summarize();
	end
endmodule : supply_monitor_event_router_tb
